// File: crypto_defines.svh
// register offsets, field positions, reset values and key codes for the status block
`ifndef CRYPTO_DEFINES_SVH
`define CRYPTO_DEFINES_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFF_STATUS 12'h000
`define OFF_CTRL 12'h004
`define OFF_CFG 12'h008
`define OFF_IRQ_STAT 12'h00c
`define OFF_IRQ_EN 12'h010
`define OFF_IRQ_CLR 12'h014
`define OFF_CORE 12'h018
// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define ST_BUSY 7
`define ST_TXTA 6
`define ST_ABORT 5
`define ST_WRAP 4
`define ST_MODE 2
`define ST_KEY 1
`define ST_PGM 0
// ----------------------------------------------------------------
// control register: bit positions
// ----------------------------------------------------------------
`define CT_GO 0
`define CT_WR 1
`define CT_ON 2
`define CT_MD 3
`define CT_SWKD 4
`define CT_SKEY 5
// ----------------------------------------------------------------
// config register fields
// ----------------------------------------------------------------
`define CF_KLEN_LO 0
`define CF_KSRC_LO 4
`define CF_PAGE_LO 8
`define CF_OPM_LO 12
`define CF_CIPH_LO 16
// ----------------------------------------------------------------
// key length, key source and operating mode codes
// ----------------------------------------------------------------
`define KLEN_128 2'h0
`define KLEN_192 2'h1
`define KLEN_256 2'h2
`define KSRC_SW 4'h0
`define KSRC_OTP1 4'h1
`define KSRC_OTP2 4'h2
`define KSRC_OTP3 4'h3
`define KSRC_OTP4 4'h4
`define KSRC_RAM1 4'h9
`define KSRC_RAM2 4'ha
`define KSRC_RAM3 4'hb
`define KSRC_RAM4 4'hc
`define OPM_CTR 3'h4
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define CTRL_RST 6'h00
`define CFG_RST 20'h00000
`define PAGE_LOCK_RST 16'h0001
`define OP_TIME_NS 3200
`define OP_CYCLES ((`OP_TIME_NS + 99) / 100)
`define OTP_TIME_NS 1600
`define OTP_CYCLES ((`OTP_TIME_NS + 99) / 100)
`endif

// File: crypto_pkg.sv
// shared types for the cipher status and key-select block
package crypto_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } eng_state_e;

  typedef struct packed {
    logic [1:0] key_len;
    logic [3:0] key_src;
    logic [3:0] page;
    logic [2:0] op_mode;
    logic [2:0] cipher_mode;
  } cfg_s;

  typedef struct packed {
    logic key_bad;
    logic otp_key;
    logic ram_key;
    logic [1:0] slot;
  } key_sel_s;
endpackage

// File: crypto_key_check.sv
// combinational key length / key source decode and validity check
`timescale 1ns/1ps
`include "crypto_defines.svh"
module crypto_key_check (
  input wire crypto_pkg::cfg_s cfg,
  input wire logic secure_key_enable,
  input wire logic software_key_disable,
  output crypto_pkg::key_sel_s sel
);
  // ----------------------------------------------------------------
  // key table decode
  // ----------------------------------------------------------------
  always_comb begin
    sel = '0;
    sel.key_bad = 1'b1;
    if (cfg.key_len == `KLEN_128) begin
      if (cfg.key_src == `KSRC_SW) begin
        sel.key_bad = software_key_disable;
      end else if (cfg.key_src == `KSRC_OTP1) begin
        sel.key_bad = secure_key_enable;
        sel.otp_key = 1'b1;
      end else if (cfg.key_src >= `KSRC_OTP2 && cfg.key_src <= `KSRC_OTP4) begin
        sel.key_bad = 1'b0;
        sel.otp_key = 1'b1;
        sel.slot = cfg.key_src[1:0] - 2'h1;
      end else if (cfg.key_src >= `KSRC_RAM1 && cfg.key_src <= `KSRC_RAM4) begin
        sel.key_bad = 1'b0;
        sel.ram_key = 1'b1;
        sel.slot = cfg.key_src[1:0] - 2'h1;
      end
    end else if (cfg.key_len == `KLEN_192 || cfg.key_len == `KLEN_256) begin
      if (cfg.key_src == `KSRC_SW) begin
        sel.key_bad = software_key_disable;
      end else if (cfg.key_src == `KSRC_OTP1) begin
        sel.key_bad = secure_key_enable;
        sel.otp_key = 1'b1;
      end else if (cfg.key_src == `KSRC_OTP2) begin
        sel.key_bad = 1'b0;
        sel.otp_key = 1'b1;
        sel.slot = 2'h1;
      end else if (cfg.key_src == `KSRC_RAM1 || cfg.key_src == `KSRC_RAM2) begin
        sel.key_bad = 1'b0;
        sel.ram_key = 1'b1;
        sel.slot = cfg.key_src[1:0] - 2'h1;
      end
    end
    // code 11 and all other sources stay bad
  end
endmodule

// File: crypto_otp_reader.sv
// one-time-programmable memory read sequencer: one read at reset release, more on request
// reading stays high for a fixed count; a start during a read is ignored
`timescale 1ns/1ps
`include "crypto_defines.svh"
module crypto_otp_reader (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  output logic reading
);
  logic [7:0] cnt_q;
  // ----------------------------------------------------------------
  // read timer; reset leaves the initial read in progress
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'(`OTP_CYCLES);
      reading <= 1'b1;
    end else if (start && !reading) begin
      cnt_q <= 8'(`OTP_CYCLES);
      reading <= 1'b1;
    end else if (reading) begin
      cnt_q <= cnt_q - 8'h01;
      reading <= (cnt_q != 8'h01);
    end
  end
endmodule

// File: crypto_status_key_select.sv
// cipher engine status flags, configuration checks and APB register file
//
// What this block does
// - busy flag high while operation runs
// - text A busy flag; software waits
// - abort flag set when software clears go
// - abort set blocks any new start
// - counter wrap sets flag; clear before go
// - invalid mode raises mode fail, blocks write
// - invalid key settings raise key fail
// - reserved or locked page blocks programming
// - flags cleared by reset or module disable
// - abort, wrap cleared when go cleared
// - checks work while engine is off
// - OTP read holds busy, key, program fail
// - key length code 11 is key error
// - OTP key one errors in secure mode
// - software key errors when disabled
// - bad length/source keeps key fail set
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "crypto_defines.svh"
module crypto_status_key_select (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q;
  crypto_pkg::cfg_s cfg_q;
  logic [15:0] page_lock_q;
  crypto_pkg::eng_state_e state_q;
  logic [7:0] op_cnt_q;
  logic [7:0] status_q;
  logic [7:0] ctr_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic done_q;
  logic wrap_q;
  logic abort_q;
  logic busy_q;
  logic txta_q;
  logic mode_bad;
  logic page_bad;
  logic otp_reading;
  logic wr_en;
  logic rd_en;
  logic go_wr;
  logic go_set_req;
  logic go_clr_req;
  logic wr_set_req;
  logic disabled;
  logic start_ok;
  logic [3:0] irq_evt;
  logic [31:0] rdata_d;
  logic slverr_d;
  crypto_pkg::key_sel_s ksel;
  logic wr_block;
  logic stat_wr;
  logic clr_wr;
  logic wrap_set;
  logic abort_set;
  logic otp_done;
  logic otp_prev_q;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  assign disabled = ctrl_q[`CT_MD];
  assign go_wr = wr_en && paddr == `OFF_CTRL;
  assign go_set_req = go_wr && pwdata[`CT_GO] && !ctrl_q[`CT_GO];
  assign go_clr_req = go_wr && !pwdata[`CT_GO] && ctrl_q[`CT_GO];
  assign wr_set_req = go_wr && pwdata[`CT_WR];

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  crypto_key_check u_key_check (
    .cfg(cfg_q),
    .secure_key_enable(ctrl_q[`CT_SKEY]),
    .software_key_disable(ctrl_q[`CT_SWKD]),
    .sel(ksel)
  );

  crypto_otp_reader u_otp (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(wr_en && paddr == `OFF_CORE && pwdata[0]),
    .reading(otp_reading)
  );

  // ----------------------------------------------------------------
  // configuration checks, evaluated even while the engine is off
  // ----------------------------------------------------------------
  assign mode_bad = cfg_q.op_mode > 3'h4 || cfg_q.cipher_mode > 3'h4;
  assign page_bad = cfg_q.page == 4'hf || page_lock_q[cfg_q.page];

  // a start needs the engine on and idle, no abort, no wrap and a clean setup
  assign start_ok = ctrl_q[`CT_ON] && !abort_q && !wrap_q && !mode_bad
    && !ksel.key_bad && !otp_reading && !disabled
    && state_q == crypto_pkg::ST_IDLE;

  // write/program is refused while any check fails or the fuses are read
  assign wr_block = mode_bad || ksel.key_bad || page_bad || otp_reading;

  // status writes only reach the two clearable flags
  assign stat_wr = wr_en && paddr == `OFF_STATUS;
  assign clr_wr = wr_en && paddr == `OFF_IRQ_CLR;

  // events that raise the sticky flags and the interrupt status bits
  assign abort_set = go_clr_req && state_q == crypto_pkg::ST_RUN;
  assign wrap_set = state_q == crypto_pkg::ST_DONE && cfg_q.op_mode == `OPM_CTR
    && ctr_q == 8'hff;
  assign otp_done = otp_prev_q && !otp_reading;
  assign irq_evt = {otp_done, abort_set, wrap_set, done_q};

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // go is only taken when a start is allowed; hardware drops it when done
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RST;
    end else begin
      if (go_wr) begin
        ctrl_q[`CT_ON] <= pwdata[`CT_ON];
        ctrl_q[`CT_MD] <= pwdata[`CT_MD];
        ctrl_q[`CT_SWKD] <= pwdata[`CT_SWKD];
        ctrl_q[`CT_SKEY] <= pwdata[`CT_SKEY];
        ctrl_q[`CT_WR] <= wr_set_req && !wr_block;
      end
      if (go_set_req) begin
        ctrl_q[`CT_GO] <= start_ok;
      end else if (go_clr_req || done_q || disabled) begin
        ctrl_q[`CT_GO] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  // key, page and mode selects; writes are taken at any time
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= 16'(`CFG_RST);
    end else if (wr_en && paddr == `OFF_CFG) begin
      cfg_q.key_len <= pwdata[`CF_KLEN_LO +: 2];
      cfg_q.key_src <= pwdata[`CF_KSRC_LO +: 4];
      cfg_q.page <= pwdata[`CF_PAGE_LO +: 4];
      cfg_q.op_mode <= pwdata[`CF_OPM_LO +: 3];
      cfg_q.cipher_mode <= pwdata[`CF_CIPH_LO +: 3];
    end
  end

  // page locks can only be added, never removed, short of a reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_lock_q <= `PAGE_LOCK_RST;
    end else if (wr_en && paddr == `OFF_CORE) begin
      page_lock_q <= page_lock_q | pwdata[31:16];
    end
  end

  // ----------------------------------------------------------------
  // engine sequencer
  // ----------------------------------------------------------------
  // runs a fixed number of cycles; clearing go or disabling stops it at once
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= crypto_pkg::ST_IDLE;
      op_cnt_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        crypto_pkg::ST_IDLE: begin
          if (go_set_req && start_ok) begin
            state_q <= crypto_pkg::ST_RUN;
            op_cnt_q <= 8'(`OP_CYCLES);
          end
        end
        crypto_pkg::ST_RUN: begin
          if (disabled || go_clr_req) begin
            state_q <= crypto_pkg::ST_IDLE;
          end else if (op_cnt_q == 8'h01) begin
            state_q <= crypto_pkg::ST_DONE;
          end else begin
            op_cnt_q <= op_cnt_q - 8'h01;
          end
        end
        crypto_pkg::ST_DONE: begin
          done_q <= 1'b1;
          state_q <= crypto_pkg::ST_IDLE;
        end
        default: begin
          state_q <= crypto_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // busy follows the run state; text A stays busy while the first half loads
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      txta_q <= 1'b0;
    end else begin
      busy_q <= state_q == crypto_pkg::ST_RUN;
      txta_q <= state_q == crypto_pkg::ST_RUN && op_cnt_q > 8'(`OP_CYCLES / 2);
    end
  end

  // ----------------------------------------------------------------
  // sticky abort and wrap flags
  // ----------------------------------------------------------------
  // a software clear of go mid-run sets abort; set wins over any clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      abort_q <= 1'b0;
    end else if (abort_set) begin
      abort_q <= 1'b1;
    end else if (disabled || go_clr_req || (stat_wr && pwdata[`ST_ABORT])) begin
      abort_q <= 1'b0;
    end
  end

  // text B counts finished counter-mode operations and flags its wrap
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctr_q <= 8'h00;
      wrap_q <= 1'b0;
    end else begin
      if (state_q == crypto_pkg::ST_DONE && cfg_q.op_mode == `OPM_CTR) begin
        ctr_q <= ctr_q + 8'h01;
      end
      if (wrap_set) begin
        wrap_q <= 1'b1;
      end else if (disabled || go_clr_req || (stat_wr && pwdata[`ST_WRAP])) begin
        wrap_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  // fuse reads force busy and the key and page fails; disable clears all
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= 8'h00;
    end else if (disabled) begin
      status_q <= 8'h00;
    end else begin
      status_q <= 8'h00;
      status_q[`ST_BUSY] <= busy_q || otp_reading;
      status_q[`ST_TXTA] <= txta_q;
      status_q[`ST_ABORT] <= abort_q;
      status_q[`ST_WRAP] <= wrap_q;
      status_q[`ST_MODE] <= mode_bad;
      status_q[`ST_KEY] <= ksel.key_bad || otp_reading;
      status_q[`ST_PGM] <= page_bad || otp_reading;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // reader is busy out of reset, so no false end-of-read edge follows reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_prev_q <= 1'b1;
    end else begin
      otp_prev_q <= otp_reading;
    end
  end

  // one sticky bit per event; an event in the clear cycle wins
  for (genvar i = 0; i < 4; i++) begin : g_irq
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        irq_stat_q[i] <= 1'b0;
      end else if (irq_evt[i]) begin
        irq_stat_q[i] <= 1'b1;
      end else if (clr_wr && pwdata[i]) begin
        irq_stat_q[i] <= 1'b0;
      end
    end
  end

  // interrupt enables, same layout as the status bits
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= 4'h0;
    end else if (wr_en && paddr == `OFF_IRQ_EN) begin
      irq_en_q <= pwdata[3:0];
    end
  end

  // level interrupt, registered
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // address decode; unmapped words answer with an error
  always_comb begin
    rdata_d = 32'h0;
    slverr_d = 1'b0;
    if (paddr == `OFF_STATUS) begin
      rdata_d[7:0] = status_q;
    end else if (paddr == `OFF_CTRL) begin
      rdata_d[5:0] = ctrl_q;
    end else if (paddr == `OFF_CFG) begin
      rdata_d[`CF_KLEN_LO +: 2] = cfg_q.key_len;
      rdata_d[`CF_KSRC_LO +: 4] = cfg_q.key_src;
      rdata_d[`CF_PAGE_LO +: 4] = cfg_q.page;
      rdata_d[`CF_OPM_LO +: 3] = cfg_q.op_mode;
      rdata_d[`CF_CIPH_LO +: 3] = cfg_q.cipher_mode;
    end else if (paddr == `OFF_IRQ_STAT) begin
      rdata_d[3:0] = irq_stat_q;
    end else if (paddr == `OFF_IRQ_EN) begin
      rdata_d[3:0] = irq_en_q;
    end else if (paddr == `OFF_IRQ_CLR) begin
      rdata_d = 32'h0;
    end else if (paddr == `OFF_CORE) begin
      rdata_d[31:16] = page_lock_q;
      rdata_d[0] = otp_reading;
    end else begin
      slverr_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // one wait state: read data is latched on the same edge that raises ready
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= slverr_d;
      end
      if (rd_en) begin
        prdata <= rdata_d;
      end
    end
  end
endmodule

// File: crypto_status_sva.sv
// port-level assertions for the cipher status block
`timescale 1ns/1ps
`include "crypto_defines.svh"
module crypto_status_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  logic [31:0] ctl_q;
  logic [31:0] cfg_q;
  logic done_w;
  logic st_w;
  logic rd_st;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  assign done_w = psel && penable && pready;
  assign st_w = done_w && !pwrite && paddr == `OFF_STATUS;
  assign rd_st = st_w && !ctl_q[`CT_MD];
  // shadow copies of control and config writes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= 32'h0;
      cfg_q <= 32'h0;
    end else if (done_w && pwrite) begin
      if (paddr == `OFF_CTRL) ctl_q <= pwdata;
      if (paddr == `OFF_CFG) cfg_q <= pwdata;
    end
  end
  AST_ACK: assert property (psel && penable |-> ##[0:8] pready)
    else $error("access not answered");
  AST_ST_ZERO: assert property (st_w |-> prdata[31:8] == 24'h0 && !prdata[3])
    else $error("unused status bits set");
  AST_KLEN_RSV: assert property (rd_st && cfg_q[1:0] == 2'h3 |-> prdata[`ST_KEY])
    else $error("reserved key length accepted");
  AST_SWKEY: assert property (rd_st && cfg_q[7:4] == `KSRC_SW && ctl_q[`CT_SWKD] |-> prdata[1])
    else $error("disabled software key accepted");
  AST_SKEY: assert property (rd_st && cfg_q[7:4] == `KSRC_OTP1 && ctl_q[`CT_SKEY] |-> prdata[1])
    else $error("secure mode key one accepted");
  AST_SRC_RSV: assert property (rd_st && cfg_q[7:4] == 4'hf |-> prdata[`ST_KEY])
    else $error("reserved key source accepted");
  AST_PAGE_LOCK: assert property (rd_st && cfg_q[11:8] == 4'h0 |-> prdata[`ST_PGM])
    else $error("locked page not flagged");
  AST_DIS_CLR: assert property (st_w && ctl_q[`CT_MD] |-> prdata[7:6] == 2'h0)
    else $error("busy flags survive disable");
endmodule
bind crypto_status_key_select crypto_status_sva chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// File: test_crypto_status_key_select.sv
// self-checking bench for the cipher status block
`timescale 1ns/1ps
`include "crypto_defines.svh"
module test_crypto_status_key_select;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] rd_v;
  logic rd_e;
  logic [31:0] seed = 32'h54;
  logic [1:0] kl;
  int err_total = 0;
  int n_checks = 0;
  crypto_status_key_select dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  always #50 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected key-fail flag from length, source and key disables
  function automatic logic key_bad(input logic [1:0] l, input logic [3:0] s, input logic sk,
    input logic sd);
    if (l == 2'h3 || (s == 4'h0 && sd) || (s == 4'h1 && sk)) return 1'b1;
    if (s == 4'h0 || s == 4'h1 || s == 4'h2 || s == 4'h9 || s == 4'ha) return 1'b0;
    return !(l == 2'h0 && (s == 4'h3 || s == 4'h4 || s == 4'hb || s == 4'hc));
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data lands in rd_v
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    rd_e = pslverr;
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(posedge core_clk);
    @(negedge core_clk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge core_clk);
    apb(1'b1, `OFF_STATUS, 32'hffffffff);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v & 32'hffffff08, 32'h0);
    apb(1'b1, `OFF_CORE, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v & 32'h83, 32'h83);
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      kl = (i < 4) ? i[1:0] : seed[1:0];
      apb(1'b1, `OFF_CTRL, {26'h0, seed[9:8], 4'h0});
      apb(1'b1, `OFF_CFG, {20'h0, 4'h1, seed[7:4], 2'h0, kl});
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rd_v[1], key_bad(kl, seed[7:4], seed[9], seed[8]));
    end
    apb(1'b1, `OFF_CFG, 32'h7100);
    apb(1'b1, `OFF_CTRL, 32'h2);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v[`ST_MODE], 32'h1);
    apb(1'b0, `OFF_CTRL, 32'h0);
    check(rd_v[`CT_WR], 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_CFG, 32'h0);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v[`ST_PGM], 32'h1);
    apb(1'b1, `OFF_CFG, 32'h100);
    apb(1'b1, `OFF_IRQ_EN, 32'hffffffff);
    apb(1'b1, `OFF_CTRL, 32'h4);
    apb(1'b1, `OFF_CTRL, 32'h5);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v[`ST_BUSY], 32'h1);
    for (int i = 0; i < 60 && rd_v[`ST_BUSY] !== 1'b0; i++) apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v[7:5], 32'h0);
    irq_is(1'b1);
    apb(1'b1, `OFF_IRQ_EN, 32'h0);
    irq_is(1'b0);
    apb(1'b1, `OFF_IRQ_EN, 32'hffffffff);
    irq_is(1'b1);
    apb(1'b1, `OFF_IRQ_CLR, 32'hffffffff);
    irq_is(1'b0);
    apb(1'b1, `OFF_CTRL, 32'h5);
    apb(1'b1, `OFF_CTRL, 32'h4);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v[`ST_ABORT], 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h8);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rd_v & 32'hc7, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    check({31'h0, rd_e}, 32'h1);
    complete_run();
  end
endmodule
